// File: logic/jtag_tap_controller.sv
/*
 * Test access port: state machine, instruction chain, data chains,
 * pad function protection and a FIFO for words written by the tester.
 * Assumes the test clock is much slower than the system clock (at least
 * four system cycles per test clock phase) and that all pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller (
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RST_B_I,
    input  wire logic                          CE_I,
    input  wire logic                          TRST_B_I,
    input  wire logic                          TCK_I,
    input  wire logic                          TMS_I,
    input  wire logic                          TDI_I,
    output logic                               TDO_O,
    output logic                               TDO_OE_O,
    input  wire logic [jtag_tap_pkg::BSR_W-1:0] BSR_PINS_I,
    output logic      [jtag_tap_pkg::BSR_W-1:0] BSR_UPD_O,
    output logic      [jtag_tap_pkg::IR_W-1:0]  INSTR_O,
    input  wire logic                          UNLOCK_WR_I,
    input  wire logic [jtag_tap_pkg::DATA_W-1:0] UNLOCK_KEY_I,
    input  wire logic                          COMMIT_WR_I,
    input  wire logic [jtag_tap_pkg::PIN_N-1:0] COMMIT_DATA_I,
    input  wire logic                          FUNC_SEL_WR_I,
    input  wire logic [jtag_tap_pkg::PIN_N-1:0] FUNC_SEL_DATA_I,
    input  wire logic                          PULL_WR_I,
    input  wire logic [jtag_tap_pkg::PIN_N-1:0] PULL_UP_DATA_I,
    input  wire logic [jtag_tap_pkg::PIN_N-1:0] PULL_DN_DATA_I,
    output logic      [jtag_tap_pkg::PIN_N-1:0] ALTERNATE_FUNCTION_SELECT_O,
    output logic      [jtag_tap_pkg::PIN_N-1:0] PULL_UP_EN_O,
    output logic      [jtag_tap_pkg::PIN_N-1:0] PULL_DN_EN_O,
    output logic                               UNLOCKED_O,
    output logic                               DATA_VALID_O,
    input  wire logic                          DATA_READY_I,
    output logic      [jtag_tap_pkg::DATA_W-1:0] DATA_O
);
    localparam int DW = jtag_tap_pkg::DATA_W;
    localparam int IW = jtag_tap_pkg::IR_W;
    localparam int BW = jtag_tap_pkg::BSR_W;

    jtag_tap_pkg::pins_s      pins;
    jtag_tap_pkg::pad_cfg_s   pad;
    jtag_tap_pkg::tap_state_e state;
    jtag_tap_pkg::tap_state_e next_state;

    logic                          tck_prev;
    logic                          tck_rise;
    logic                          tck_fall;
    logic                          tap_reset;
    logic [IW-1:0]                 ir_sr;
    logic [IW-1:0]                 ir_upd;
    logic [DW-1:0]                 dr_sr;
    logic [jtag_tap_pkg::LEN_W-1:0] dr_len;
    logic                          dr_active;
    logic                          fifo_push;
    logic [DW-1:0]                 fifo_word;
    logic                          fifo_ready;
    logic                          overflow;
    logic [jtag_tap_pkg::PIN_N-1:0] commit;

    // Unimplemented codes fall back to bypass
    function automatic logic [IW-1:0] decode_ir(input logic [IW-1:0] code);
        unique case (code)
            jtag_tap_pkg::INS_EXTEST,
            jtag_tap_pkg::INS_INTEST,
            jtag_tap_pkg::INS_SAMPLE,
            jtag_tap_pkg::INS_IDCODE,
            jtag_tap_pkg::INS_USER:   decode_ir = code;
            default:                  decode_ir = jtag_tap_pkg::INS_BYPASS;
        endcase
    endfunction : decode_ir

    // Chains that take part in capture, shift and update
    function automatic logic chain_used(input logic [IW-1:0] ins);
        chain_used = (ins != jtag_tap_pkg::INS_EXTEST) && (ins != jtag_tap_pkg::INS_INTEST);
    endfunction : chain_used

    function automatic jtag_tap_pkg::tap_state_e tap_next(
        input jtag_tap_pkg::tap_state_e cur,
        input logic                     tms
    );
        unique case (cur)
            jtag_tap_pkg::TLR:  tap_next = tms ? jtag_tap_pkg::TLR  : jtag_tap_pkg::RTI;
            jtag_tap_pkg::RTI:  tap_next = tms ? jtag_tap_pkg::SDRS : jtag_tap_pkg::RTI;
            jtag_tap_pkg::SDRS: tap_next = tms ? jtag_tap_pkg::SIRS : jtag_tap_pkg::CDR;
            jtag_tap_pkg::CDR:  tap_next = tms ? jtag_tap_pkg::E1DR : jtag_tap_pkg::SHDR;
            jtag_tap_pkg::SHDR: tap_next = tms ? jtag_tap_pkg::E1DR : jtag_tap_pkg::SHDR;
            jtag_tap_pkg::E1DR: tap_next = tms ? jtag_tap_pkg::UDR  : jtag_tap_pkg::PDR;
            jtag_tap_pkg::PDR:  tap_next = tms ? jtag_tap_pkg::E2DR : jtag_tap_pkg::PDR;
            jtag_tap_pkg::E2DR: tap_next = tms ? jtag_tap_pkg::UDR  : jtag_tap_pkg::SHDR;
            jtag_tap_pkg::UDR:  tap_next = tms ? jtag_tap_pkg::SDRS : jtag_tap_pkg::RTI;
            jtag_tap_pkg::SIRS: tap_next = tms ? jtag_tap_pkg::TLR  : jtag_tap_pkg::CIR;
            jtag_tap_pkg::CIR:  tap_next = tms ? jtag_tap_pkg::E1IR : jtag_tap_pkg::SHIR;
            jtag_tap_pkg::SHIR: tap_next = tms ? jtag_tap_pkg::E1IR : jtag_tap_pkg::SHIR;
            jtag_tap_pkg::E1IR: tap_next = tms ? jtag_tap_pkg::UIR  : jtag_tap_pkg::PIR;
            jtag_tap_pkg::PIR:  tap_next = tms ? jtag_tap_pkg::E2IR : jtag_tap_pkg::PIR;
            jtag_tap_pkg::E2IR: tap_next = tms ? jtag_tap_pkg::UIR  : jtag_tap_pkg::SHIR;
            jtag_tap_pkg::UIR:  tap_next = tms ? jtag_tap_pkg::SDRS : jtag_tap_pkg::RTI;
            default:            tap_next = jtag_tap_pkg::TLR;
        endcase
    endfunction : tap_next

    // Data pins are delayed with the clock pin, so they stay aligned
    pin_sync #(
        .W ($bits(jtag_tap_pkg::pins_s))
    ) u_pin_sync (
        .clk_i   (CLK_SYS_I),
        .rst_b_i (RST_B_I),
        .ce_i    (CE_I),
        .d_i     ({TRST_B_I, TCK_I, TMS_I, TDI_I, BSR_PINS_I}),
        .q_o     (pins)
    );

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            tck_prev <= 1'b0;
        end else if (CE_I) begin
            tck_prev <= pins.tck;
        end
    end

    // Apart from test reset, no edge means no change in the test port logic below
    assign tck_rise   = pins.tck && !tck_prev;
    assign tck_fall   = !pins.tck && tck_prev;
    assign tap_reset  = !pins.trst_b;
    assign next_state = tap_next(state, pins.tms);

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            state <= jtag_tap_pkg::TLR;
        end else if (CE_I) begin
            if (tap_reset) begin
                state <= jtag_tap_pkg::TLR;
            end else if (tck_rise) begin
                state <= next_state;
            end
        end
    end

    always_comb begin
        unique case (ir_upd)
            jtag_tap_pkg::INS_IDCODE: dr_len = jtag_tap_pkg::LEN_IDCODE;
            jtag_tap_pkg::INS_SAMPLE: dr_len = jtag_tap_pkg::LEN_SAMPLE;
            jtag_tap_pkg::INS_USER:   dr_len = jtag_tap_pkg::LEN_USER;
            default:                  dr_len = jtag_tap_pkg::LEN_BYPASS;
        endcase
    end

    assign dr_active = chain_used(ir_upd);

    // Instruction chain and its update register
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            ir_sr  <= jtag_tap_pkg::IR_CAPTURE;
            ir_upd <= jtag_tap_pkg::INS_IDCODE;
        end else if (CE_I) begin
            if (tap_reset || state == jtag_tap_pkg::TLR) begin
                ir_upd <= jtag_tap_pkg::INS_IDCODE;
            end else if (tck_rise && state == jtag_tap_pkg::CIR) begin
                ir_sr <= jtag_tap_pkg::IR_CAPTURE;
            end else if (tck_rise && state == jtag_tap_pkg::SHIR) begin
                ir_sr <= {pins.tdi, ir_sr[IW-1:1]};
            end else if (tck_fall && state == jtag_tap_pkg::UIR) begin
                ir_upd <= decode_ir(ir_sr);
            end
        end
    end

    // Shared data shift register; the selected length sets where TDI enters
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            dr_sr <= '0;
        end else if (CE_I && tck_rise && dr_active && !tap_reset) begin
            if (state == jtag_tap_pkg::CDR) begin
                unique case (ir_upd)
                    jtag_tap_pkg::INS_IDCODE: dr_sr <= jtag_tap_pkg::IDCODE_VALUE;
                    jtag_tap_pkg::INS_SAMPLE: dr_sr <= {{(DW-BW){1'b0}}, pins.bsr};
                    jtag_tap_pkg::INS_USER:   dr_sr <= {{(DW-2){1'b0}}, overflow, fifo_ready};
                    default:                  dr_sr <= '0;
                endcase
            end else if (state == jtag_tap_pkg::SHDR) begin
                for (int i = 0; i < DW; i++) begin
                    if (i == int'(dr_len) - 1) begin
                        dr_sr[i] <= pins.tdi;
                    end else if (i < int'(dr_len) - 1) begin
                        dr_sr[i] <= dr_sr[i+1];
                    end else begin
                        dr_sr[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Parallel update registers, loaded on the falling edge in Update-DR
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            BSR_UPD_O <= '0;
            fifo_push <= 1'b0;
            fifo_word <= '0;
        end else if (CE_I) begin
            fifo_push <= 1'b0;
            if (tck_fall && !tap_reset && state == jtag_tap_pkg::UDR && dr_active) begin
                if (ir_upd == jtag_tap_pkg::INS_SAMPLE) begin
                    BSR_UPD_O <= dr_sr[BW-1:0];
                end
                if (ir_upd == jtag_tap_pkg::INS_USER) begin
                    fifo_push <= fifo_ready;
                    fifo_word <= dr_sr;
                end
            end
        end
    end

    // Sticky loss flag; set wins, cleared by the next capture
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            overflow <= 1'b0;
        end else if (CE_I) begin
            if (tck_fall && state == jtag_tap_pkg::UDR && ir_upd == jtag_tap_pkg::INS_USER && !fifo_ready) begin
                overflow <= 1'b1;
            end else if (tck_rise && state == jtag_tap_pkg::CDR && ir_upd == jtag_tap_pkg::INS_USER) begin
                overflow <= 1'b0;
            end
        end
    end

    // Output stage: changes on falling test clock edges; test reset also drops the enable at once
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else if (CE_I) begin
            if (tap_reset) begin
                TDO_OE_O <= 1'b0;
            end else if (tck_fall) begin
                if (state == jtag_tap_pkg::SHIR) begin
                    TDO_O    <= ir_sr[0];
                    TDO_OE_O <= 1'b1;
                end else if (state == jtag_tap_pkg::SHDR && dr_active) begin
                    TDO_O    <= dr_sr[0];
                    TDO_OE_O <= 1'b1;
                end else begin
                    TDO_OE_O <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            INSTR_O <= jtag_tap_pkg::INS_IDCODE;
        end else if (CE_I) begin
            INSTR_O <= ir_upd;
        end
    end

    // Pin function protection: key unlocks, commit bits open single pins
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            UNLOCKED_O <= 1'b0;
            commit     <= jtag_tap_pkg::COMMIT_RESET;
        end else if (CE_I) begin
            if (UNLOCK_WR_I) begin
                UNLOCKED_O <= (UNLOCK_KEY_I == jtag_tap_pkg::UNLOCK_KEY);
            end
            if (COMMIT_WR_I && UNLOCKED_O) begin
                commit <= COMMIT_DATA_I;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            pad.func_sel <= jtag_tap_pkg::FUNC_SEL_RESET;
            pad.pull_up  <= jtag_tap_pkg::PULL_UP_RESET;
            pad.pull_dn  <= jtag_tap_pkg::PULL_DN_RESET;
        end else if (CE_I) begin
            if (FUNC_SEL_WR_I) begin
                // Uncommitted bits keep their value, so a stray write cannot lock out the tester
                pad.func_sel <= (FUNC_SEL_DATA_I & commit) | (pad.func_sel & ~commit);
            end
            if (PULL_WR_I) begin
                pad.pull_up <= PULL_UP_DATA_I;
                pad.pull_dn <= PULL_DN_DATA_I;
            end
        end
    end

    assign ALTERNATE_FUNCTION_SELECT_O = pad.func_sel;
    assign PULL_UP_EN_O                = pad.pull_up;
    assign PULL_DN_EN_O                = pad.pull_dn;

    word_fifo #(
        .WIDTH (DW),
        .DEPTH (jtag_tap_pkg::FIFO_DEPTH)
    ) u_word_fifo (
        .clk_i       (CLK_SYS_I),
        .rst_b_i     (RST_B_I),
        .ce_i        (CE_I),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (fifo_word),
        .out_valid_o (DATA_VALID_O),
        .out_ready_i (DATA_READY_I),
        .out_data_o  (DATA_O)
    );
endmodule : jtag_tap_controller
`default_nettype wire

// File: logic/jtag_tap_pkg.sv
/*
 * Constants, state encoding and carrier types for the test access port.
 * Assumes one system clock domain; all pins are sampled by that clock.
 */
// Summary of operation
// - Test reset pin low forces and holds the state machine in Test-Logic-Reset.
// - Entering Test-Logic-Reset loads the identification instruction.
// - Mode select sampled on each test clock rise picks the next state.
// - Five rises with mode select high reach Test-Logic-Reset from anywhere.
// - Data input sampled on each rise shifts into the selected chain.
// - Data output changes on the falling test clock edge.
// - Data output is driven only while a chain shifts out.
// - A stopped test clock keeps state and all chain contents.
// - Power-on reset also forces Test-Logic-Reset.
// - Unimplemented instruction codes decode as the bypass instruction.
// - External and internal test instructions leave every data chain untouched.
// - The updated instruction selects the data chain.
// - The state decides instruction or data chain and capture, shift, update timing.
// - After reset the shared pins take the test-port function.
// - Pin function changes need an unlock key and a commit bit.
// - After reset pull-ups are on and pull-downs off on all five pins.
// - The instruction chain is four bits long.
// - Update states copy shifted contents into the parallel registers.
package jtag_tap_pkg;
    localparam int IR_W       = 4;
    localparam int DATA_W     = 32;
    localparam int BSR_W      = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int PIN_N      = 5;
    localparam int LEN_W      = 6;

    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_INTEST = 4'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h4;
    localparam logic [IR_W-1:0] INS_USER   = 4'h8;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    // Arbitrary identification value, least bit set as required
    localparam logic [DATA_W-1:0] IDCODE_VALUE = 32'h0000_1001;
    // Arbitrary unlock key
    localparam logic [DATA_W-1:0] UNLOCK_KEY   = 32'h5A5A_C3C3;

    localparam logic [LEN_W-1:0] LEN_BYPASS = 6'h01;
    localparam logic [LEN_W-1:0] LEN_IDCODE = 6'h20;
    localparam logic [LEN_W-1:0] LEN_SAMPLE = 6'h08;
    localparam logic [LEN_W-1:0] LEN_USER   = 6'h20;

    localparam logic [PIN_N-1:0] FUNC_SEL_RESET = 5'h1F;
    localparam logic [PIN_N-1:0] PULL_UP_RESET  = 5'h1F;
    localparam logic [PIN_N-1:0] PULL_DN_RESET  = 5'h00;
    localparam logic [PIN_N-1:0] COMMIT_RESET   = 5'h00;

    typedef enum logic [15:0] {
        TLR  = 16'h0001,
        RTI  = 16'h0002,
        SDRS = 16'h0004,
        CDR  = 16'h0008,
        SHDR = 16'h0010,
        E1DR = 16'h0020,
        PDR  = 16'h0040,
        E2DR = 16'h0080,
        UDR  = 16'h0100,
        SIRS = 16'h0200,
        CIR  = 16'h0400,
        SHIR = 16'h0800,
        E1IR = 16'h1000,
        PIR  = 16'h2000,
        E2IR = 16'h4000,
        UIR  = 16'h8000
    } tap_state_e;

    typedef struct packed {
        logic             trst_b;
        logic             tck;
        logic             tms;
        logic             tdi;
        logic [BSR_W-1:0] bsr;
    } pins_s;

    typedef struct packed {
        logic [PIN_N-1:0] func_sel;
        logic [PIN_N-1:0] pull_up;
        logic [PIN_N-1:0] pull_dn;
    } pad_cfg_s;
endpackage : jtag_tap_pkg

// File: logic/pin_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes each bit is independent; no multi-bit coherence is promised.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            q_o  <= '0;
        end else if (ce_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: logic/word_fifo.sv
/*
 * Synchronous FIFO with a registered read stage, valid/ready both sides.
 * Assumes one clock; holding storage is DEPTH words plus the output stage.
 */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    assign pop        = (count != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce_i) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (ce_i) begin
            if (pop) begin
                out_valid_o <= 1'b1;
                out_data_o  <= mem[rd_ptr];
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule : word_fifo
`default_nettype wire

// File: verif/jtag_tap_controller_properties.sv
/* Concurrent checks on the test port top level, bound into it.
   Assumes CE_I stays high and each test clock phase spans several system cycles. */
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller_properties (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_B_I,
    input wire logic        TRST_B_I,
    input wire logic        TCK_I,
    input wire logic        TDO_O,
    input wire logic        TDO_OE_O,
    input wire logic [3:0]  INSTR_O,
    input wire logic [7:0]  BSR_UPD_O,
    input wire logic        UNLOCK_WR_I,
    input wire logic [31:0] UNLOCK_KEY_I,
    input wire logic        FUNC_SEL_WR_I,
    input wire logic [4:0]  ALTERNATE_FUNCTION_SELECT_O,
    input wire logic [4:0]  PULL_UP_EN_O,
    input wire logic [4:0]  PULL_DN_EN_O,
    input wire logic        UNLOCKED_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);
    a_trst_forces_idcode:
        assert property (!TRST_B_I [*6] |=> INSTR_O == 4'h4 && !TDO_OE_O) else $error("test reset ignored");
    a_por_defaults:
        assert property ($rose(RST_B_I) |-> INSTR_O == 4'h4 && ALTERNATE_FUNCTION_SELECT_O == 5'h1F
            && PULL_UP_EN_O == 5'h1F && PULL_DN_EN_O == 5'h00 && !UNLOCKED_O && !TDO_OE_O) else $error("bad reset");
    a_tdo_after_fall:
        assert property ($changed(TDO_O) |-> !$past(TCK_I, 2)) else $error("data out moved off fall");
    a_oe_after_fall:
        assert property ($rose(TDO_OE_O) |-> !$past(TCK_I, 2)) else $error("drive began off fall");
    a_instr_decoded:
        assert property (INSTR_O inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF}) else $error("undecoded instr");
    a_idle_keeps_regs:
        assert property ((TRST_B_I && $stable(TCK_I)) [*8] |=> $stable(INSTR_O) && $stable(BSR_UPD_O)
            && $stable(TDO_O)) else $error("state lost with clock stopped");
    a_func_sel_guard:
        assert property ($changed(ALTERNATE_FUNCTION_SELECT_O) |-> $past(FUNC_SEL_WR_I)) else $error("func sel moved");
    a_unlock_key:
        assert property ($past(UNLOCK_WR_I) |-> UNLOCKED_O == ($past(UNLOCK_KEY_I) == jtag_tap_pkg::UNLOCK_KEY))
            else $error("unlock wrong");
    c_shift_out: cover property ($rose(TDO_OE_O));
    c_trst: cover property (!TRST_B_I [*6]);
    c_func_sel: cover property ($changed(ALTERNATE_FUNCTION_SELECT_O));
endmodule : jtag_tap_controller_properties
bind jtag_tap_controller jtag_tap_controller_properties jtag_tap_controller_properties_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .TRST_B_I(TRST_B_I), .TCK_I(TCK_I), .TDO_O(TDO_O),
    .TDO_OE_O(TDO_OE_O), .INSTR_O(INSTR_O), .BSR_UPD_O(BSR_UPD_O), .UNLOCK_WR_I(UNLOCK_WR_I),
    .UNLOCK_KEY_I(UNLOCK_KEY_I), .FUNC_SEL_WR_I(FUNC_SEL_WR_I), .UNLOCKED_O(UNLOCKED_O),
    .ALTERNATE_FUNCTION_SELECT_O(ALTERNATE_FUNCTION_SELECT_O), .PULL_UP_EN_O(PULL_UP_EN_O),
    .PULL_DN_EN_O(PULL_DN_EN_O));
`default_nettype wire

// File: verif/jtag_tester_model.sv
/* Behavioural test-port tester: makes the 80 ns test clock only within frames.
   Assumes frames start from Run-Test-Idle; a released data out reads as pulled up. */
`timescale 1ns/1ps
`default_nettype none
module jtag_tester_model (
    output var logic tck_o,
    output var logic tms_o,
    output var logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #40 tck_o = 1'b1;
        tdo = tdo_oe_i ? tdo_i : 1'b1;
        #40 tck_o = 1'b0;
    endtask : step
    task automatic go_reset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : go_reset
    task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        // Offset keeps test clock edges away from system edges
        #3;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : shift
endmodule : jtag_tester_model
`default_nettype wire

// File: verif/test_jtag_tap_controller.sv
/* Self-checking bench for the test access port with its tester model.
   Assumes the checker is bound in; clock enable stays high throughout. */
`timescale 1ns/1ps
`default_nettype none
module test_jtag_tap_controller;
    typedef struct {logic [3:0] code, dec; int n; logic [31:0] din, exp;} row_s;
    row_s rows [5] = '{'{4'h4, 4'h4, 32, 32'h0, jtag_tap_pkg::IDCODE_VALUE}, '{4'hF, 4'hF, 8, 32'hA5, 32'h4A},
        '{4'h3, 4'hF, 8, 32'hA5, 32'h4A}, '{4'h9, 4'hF, 8, 32'hA5, 32'h4A}, '{4'h2, 4'h2, 8, 32'h3C, 32'h96}};
    logic        clk, rst_b, trst_b, tck, tms, tdi, tdo, tdo_oe, unlocked, dvalid, dready;
    logic [3:0]  wr, instr;
    logic [4:0]  alt, pull_up, pull_dn;
    logic [7:0]  bsr_pins, bsr_upd;
    logic [31:0] bus, dout, got;
    int          failures = 0;
    int          compares = 0;
    int          cnt = 0;
    jtag_tap_controller jtag_tap_controller_i (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .TRST_B_I(trst_b),
        .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .BSR_PINS_I(bsr_pins),
        .BSR_UPD_O(bsr_upd), .INSTR_O(instr), .UNLOCK_WR_I(wr[0]), .UNLOCK_KEY_I(bus), .COMMIT_WR_I(wr[1]),
        .COMMIT_DATA_I(bus[4:0]), .FUNC_SEL_WR_I(wr[2]), .FUNC_SEL_DATA_I(bus[4:0]), .PULL_WR_I(wr[3]),
        .PULL_UP_DATA_I(bus[4:0]), .PULL_DN_DATA_I(bus[9:5]), .ALTERNATE_FUNCTION_SELECT_O(alt),
        .PULL_UP_EN_O(pull_up), .PULL_DN_EN_O(pull_dn), .UNLOCKED_O(unlocked), .DATA_VALID_O(dvalid),
        .DATA_READY_I(dready), .DATA_O(dout));
    jtag_tester_model jtag_tester_model_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, g, e);
        end
    endtask : chk
    task automatic pulse(input int k, input logic [31:0] d);
        @(posedge clk) begin
            wr[k] <= 1'b1;
            bus <= d;
        end
        @(posedge clk) wr <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic give_verdict();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        trst_b = 1'b1;
        wr = 4'h0;
        bus = '0;
        dready = 1'b0;
        bsr_pins = 8'h96;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 chk(instr, 4'h4, "reset instr");
        chk(alt, 5'h1F, "reset func sel");
        chk({pull_up, pull_dn}, 10'h3E0, "reset pulls");
        $display("reset test done");
        repeat (4) @(posedge clk);
        jtag_tester_model_i.go_reset();
        foreach (rows[k]) begin
            jtag_tester_model_i.shift(1'b1, 4, rows[k].code, got);
            chk(got, 32'h1, "ir capture");
            chk(instr, rows[k].dec, "decode");
            jtag_tester_model_i.shift(1'b0, rows[k].n, rows[k].din, got);
            chk(got, rows[k].exp, "dr shift");
        end
        chk(bsr_upd, 8'h3C, "sample update");
        $display("row tests done");
        // Inert instructions: data out released, so the pull-up reads back
        for (int c = 0; c < 2; c++) begin
            jtag_tester_model_i.shift(1'b1, 4, c, got);
            jtag_tester_model_i.shift(1'b0, 8, 32'h00, got);
            chk(got, 32'hFF, "inert shift");
            chk(bsr_upd, 8'h3C, "inert update");
        end
        jtag_tester_model_i.go_reset();
        chk(instr, 4'h4, "tms reset");
        jtag_tester_model_i.shift(1'b1, 4, 32'hF, got);
        @(posedge clk) trst_b <= 1'b0;
        repeat (8) @(posedge clk);
        chk({tdo_oe, instr}, 5'h04, "trst");
        trst_b <= 1'b1;
        jtag_tester_model_i.go_reset();
        $display("reset path tests done");
        pulse(2, 32'h0);
        chk(alt, 5'h1F, "locked write");
        pulse(0, jtag_tap_pkg::UNLOCK_KEY);
        pulse(1, 32'h01);
        pulse(2, 32'h0);
        chk({unlocked, alt}, 6'h3E, "commit write");
        pulse(3, 32'h20F);
        chk({pull_up, pull_dn}, 10'h1F0, "pull write");
        $display("pad tests done");
        // Fill past 16 plus output stage with the consumer stalled
        jtag_tester_model_i.shift(1'b1, 4, 32'h8, got);
        for (int i = 1; i <= 19; i++) jtag_tester_model_i.shift(1'b0, 32, i, got);
        chk(got, 32'h2, "overflow flag");
        @(posedge clk) dready <= 1'b1;
        for (int t = 0; t < 40; t++) begin
            @(posedge clk);
            if (dvalid === 1'b1) begin
                chk(dout, cnt + 1, "fifo word");
                cnt++;
            end
        end
        chk(cnt, 17, "fifo count");
        $display("fifo test done");
        give_verdict();
    end
endmodule : test_jtag_tap_controller
`default_nettype wire
